// ### motor_stop_method_sequencer.sv
/*
 stop method sequencer: ramp, coast, DC brake stop, timed coast, start and
 terminal DC injection, analog brake current and emergency stop.
 assumes all inputs synchronous to sys_clk and settings held steady while used.
*/
`timescale 1ns/1ps
module motor_stop_method_sequencer #(
    parameter int unsigned TICK_CYCLES = stop_seq_pkg::STEP_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // commands and terminals
    input wire logic run_cmd,
    input wire logic jog_cmd,
    input wire logic [stop_seq_pkg::NUM_DI-1:0] di_level,
    input wire logic [stop_seq_pkg::NUM_DI-1:0][7:0] digital_input_function_select,
    input wire logic [11:0] ai_second_level,
    input wire logic [11:0] ai_third_level,
    input wire logic [7:0] analog_input_second_function,
    input wire logic [7:0] analog_input_third_function,
    // settings
    input wire logic [1:0] stop_method_select,
    input wire logic [1:0] low_freq_operation_select,
    input wire logic [2:0] control_method_select,
    input wire stop_seq_pkg::freq_t freq_reference,
    input wire stop_seq_pkg::freq_t dc_brake_start_freq,
    input wire logic [6:0] dc_brake_current,
    input wire logic [9:0] dc_brake_start_time,
    input wire logic [9:0] dc_brake_stop_time,
    input wire logic [7:0] min_baseblock_time,
    input wire logic [15:0] decel_time_first,
    input wire logic [15:0] fast_stop_time,
    input wire logic accel_decel_time_unit,
    input wire logic [6:0] motor_no_load_current,
    input wire stop_seq_pkg::freq_t max_output_freq,
    input wire stop_seq_pkg::freq_t min_output_freq,
    // power stage and status
    output stop_seq_pkg::freq_t output_freq,
    output logic output_gate_on,
    output logic dc_inject,
    output logic [6:0] dc_current_pct,
    output logic zero_speed_hold,
    output logic output_blocked_state,
    output logic run_locked,
    output logic estop_latched,
    output stop_seq_pkg::freq_t captured_freq
);
    import stop_seq_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    seq_state_t state, next_state;
    timer_if bb_t ();
    timer_if dc_t ();
    steps_t tick_cnt;
    logic tick;
    logic run_any, run_q, stop_edge;
    logic estop_active, term_dc;
    logic fv;
    logic ai_sel2, ai_sel3;
    logic [18:0] ai_prod;
    logic [6:0] brake_pct, inj_pct;
    freq_t dc_start_thr, run_target;
    logic low_shutoff;
    steps_t decel_thr, fast_thr, ramp_thr, ramp_acc;
    logic ramp_step, ramping;
    logic [39:0] dcb_prod, coast_prod;
    steps_t dcb_steps, coast_steps, bb_steps;

    // ----------------------------------------
    // step tick and timers
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt <= 32'h00000000;
        end else if (tick) begin
            tick_cnt <= 32'h00000000;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
        end
    end
    assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));
    assign bb_t.tick = tick;
    assign dc_t.tick = tick;

    step_timer u_bb_timer (.sys_clk(sys_clk), .rst(rst), .t(bb_t.tmr));
    step_timer u_dc_timer (.sys_clk(sys_clk), .rst(rst), .t(dc_t.tmr));

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    assign run_any = run_cmd | jog_cmd;
    assign stop_edge = run_q & ~run_any & (state == ST_RUN);
    assign fv = (control_method_select == CTRL_FLUX_VECTOR);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_any;
        end
    end

    always_comb begin
        estop_active = 1'b0;
        term_dc = 1'b0;
        for (int i = 0; i < NUM_DI; i++) begin
            if (digital_input_function_select[i] == DI_ESTOP_NO && di_level[i]) begin
                estop_active = 1'b1;
            end
            if (digital_input_function_select[i] == DI_ESTOP_NC && !di_level[i]) begin
                estop_active = 1'b1;
            end
            if (digital_input_function_select[i] == DI_DC_BRAKE && di_level[i]) begin
                term_dc = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // brake current
    // ----------------------------------------
    assign ai_sel2 = (analog_input_second_function == AI_DC_CURRENT);
    assign ai_sel3 = (analog_input_third_function == AI_DC_CURRENT);

    always_comb begin
        ai_prod = 19'(ai_sel2 ? ai_second_level : ai_third_level) * 19'(PCT_FULL);
        ai_prod = ai_prod / AI_FULL_SCALE;
        if (ai_sel2 || ai_sel3) begin
            brake_pct = ai_prod[6:0];
        end else if (dc_brake_current > PCT_FULL) begin
            brake_pct = PCT_FULL;
        end else begin
            brake_pct = dc_brake_current;
        end
        if (fv && state == ST_START_DC) begin
            inj_pct = (motor_no_load_current > PCT_FULL) ? PCT_FULL :
                      motor_no_load_current;
        end else begin
            inj_pct = brake_pct;
        end
    end

    // ----------------------------------------
    // durations in 0.01 s steps
    // ----------------------------------------
    always_comb begin
        dcb_prod = 40'(dc_brake_stop_time) * 40'(INJ_SCALE) * 40'(captured_freq);
        coast_prod = 40'(decel_time_first) * 40'(TENTHS_TO_STEPS) * 40'(output_freq);
        if (max_output_freq == FREQ_RESET) begin
            dcb_steps = 32'(dc_brake_stop_time);
            coast_steps = 32'(decel_time_first) * TENTHS_TO_STEPS;
        end else begin
            dcb_prod = dcb_prod / 40'(max_output_freq);
            coast_prod = coast_prod / 40'(max_output_freq);
            dcb_steps = dcb_prod[31:0];
            coast_steps = coast_prod[31:0];
        end
        bb_steps = 32'(min_baseblock_time) * TENTHS_TO_STEPS;
        decel_thr = 32'(decel_time_first) * TENTHS_TO_STEPS;
        if (accel_decel_time_unit == UNIT_HUNDREDTHS) begin
            fast_thr = 32'(fast_stop_time);
        end else begin
            fast_thr = 32'(fast_stop_time) * TENTHS_TO_STEPS;
        end
    end

    // ----------------------------------------
    // frequency targets
    // ----------------------------------------
    assign dc_start_thr = (dc_brake_start_freq < min_output_freq) ? min_output_freq :
                          dc_brake_start_freq;
    assign low_shutoff = (freq_reference < min_output_freq) &&
                         (low_freq_operation_select == LOWF_SHUTOFF);

    always_comb begin
        run_target = freq_reference;
        if (freq_reference < min_output_freq) begin
            unique case (low_freq_operation_select)
                LOWF_FOLLOW: run_target = freq_reference;
                LOWF_SHUTOFF: run_target = FREQ_RESET;
                LOWF_CLAMP: run_target = min_output_freq;
                LOWF_ZERO: run_target = FREQ_RESET;
            endcase
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (run_any && !estop_latched && !estop_active) begin
                    next_state = (dc_brake_start_time != START_TIME_DEFAULT) ? ST_START_DC :
                                 ST_RUN;
                end else if (term_dc && !run_any) begin
                    next_state = ST_TERM_DC;
                end
            end
            ST_START_DC: begin
                if (!run_any || estop_active) begin
                    next_state = ST_IDLE;
                end else if (dc_t.done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (estop_active) begin
                    next_state = ST_ESTOP;
                end else if (!run_any) begin
                    unique case (stop_method_select)
                        STOP_RAMP: next_state = ST_DECEL;
                        STOP_COAST: next_state = ST_COAST;
                        STOP_DC_BRAKE: next_state = ST_BB_WAIT;
                        STOP_COAST_TIMER: next_state = ST_COAST;
                    endcase
                end
            end
            ST_DECEL: begin
                if (estop_active) begin
                    next_state = ST_ESTOP;
                end else if (run_any) begin
                    next_state = ST_RUN;
                end else if (output_freq < dc_start_thr || output_freq == FREQ_RESET) begin
                    next_state = (fv && low_freq_operation_select == LOWF_SHUTOFF) ? ST_IDLE :
                                 ST_STOP_DC;
                end
            end
            ST_STOP_DC: begin
                if (run_any && !estop_active) begin
                    next_state = ST_RUN;
                end else if (dc_t.done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_COAST: begin
                if (bb_t.done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_BB_WAIT: begin
                if (bb_t.done) begin
                    next_state = ST_DCB_STOP;
                end
            end
            ST_DCB_STOP: begin
                if (dc_t.done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_TERM_DC: begin
                if (run_any || !term_dc) begin
                    next_state = ST_IDLE;
                end
            end
            ST_ESTOP: begin
                if (output_freq == FREQ_RESET) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // timer loads on entry into a timed state
    always_comb begin
        bb_t.load = (next_state != state) &&
                    (next_state == ST_COAST || next_state == ST_BB_WAIT);
        bb_t.load_value = (stop_method_select == STOP_COAST_TIMER) ? coast_steps :
                          bb_steps;
        dc_t.load = (next_state != state) && (next_state == ST_START_DC ||
                    next_state == ST_STOP_DC || next_state == ST_DCB_STOP);
        if (next_state == ST_START_DC) begin
            dc_t.load_value = 32'(dc_brake_start_time);
        end else if (next_state == ST_DCB_STOP) begin
            dc_t.load_value = dcb_steps;
        end else begin
            dc_t.load_value = 32'(dc_brake_stop_time);
        end
    end

    // ----------------------------------------
    // ramp and frequency
    // ----------------------------------------
    assign ramping = (state == ST_DECEL) || (state == ST_ESTOP);
    assign ramp_thr = (state == ST_ESTOP) ? fast_thr : decel_thr;
    assign ramp_step = ramping && (ramp_acc >= ramp_thr) && (output_freq != FREQ_RESET);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ramp_acc <= 32'h00000000;
        end else if (!ramping) begin
            ramp_acc <= 32'h00000000;
        end else begin
            ramp_acc <= ramp_acc + (tick ? 32'(max_output_freq) : 32'h00000000) -
                        (ramp_step ? ramp_thr : 32'h00000000);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            output_freq <= FREQ_RESET;
        end else if (state == ST_RUN) begin
            output_freq <= run_target;
        end else if (ramping) begin
            if (ramp_step) begin
                output_freq <= output_freq - 16'h0001;
            end
        end else begin
            output_freq <= FREQ_RESET;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            captured_freq <= FREQ_RESET;
        end else if (stop_edge) begin
            captured_freq <= output_freq;
        end
    end

    // ----------------------------------------
    // lockout and status
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            estop_latched <= 1'b0;
        end else if (next_state == ST_ESTOP) begin
            estop_latched <= 1'b1;
        end else if (state == ST_IDLE && !run_any && !estop_active) begin
            estop_latched <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dc_current_pct <= 7'h00;
        end else begin
            dc_current_pct <= inj_pct;
        end
    end

    assign zero_speed_hold = (state == ST_STOP_DC) && fv &&
                             (low_freq_operation_select == LOWF_ZERO);
    assign dc_inject = ((state == ST_STOP_DC) && !zero_speed_hold) || (state == ST_START_DC) ||
                       (state == ST_DCB_STOP) || (state == ST_TERM_DC);
    assign output_blocked_state = (state == ST_COAST) || (state == ST_BB_WAIT);
    assign output_gate_on = ((state == ST_RUN) && !low_shutoff) || ramping || dc_inject ||
                            zero_speed_hold;
    assign run_locked = output_blocked_state || estop_latched;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_ramp_on_stop: assert property (
        state == ST_RUN && !run_any && !estop_active && stop_method_select == STOP_RAMP
        |=> state == ST_DECEL)
        else $error("ramp stop not entered");
    a_ramp_no_rise: assert property (
        state == ST_DECEL && $past(state) == ST_DECEL |-> output_freq <= $past(output_freq))
        else $error("frequency rose during ramp");
    a_coast_cuts: assert property (state == ST_COAST |-> !output_gate_on && !dc_inject)
        else $error("output active while coasting");
    a_coast_lockout: assert property (
        state == ST_COAST && !bb_t.done |=> state == ST_COAST)
        else $error("coast left before lockout ended");
    a_bb_then_dc: assert property (
        state == ST_BB_WAIT && bb_t.done |=> state == ST_DCB_STOP && dc_inject)
        else $error("DC brake stop did not follow baseblock");
    a_term_dc_hold: assert property (
        state == ST_TERM_DC |-> dc_inject && output_freq == 16'h0000)
        else $error("terminal DC brake not injecting");
    a_term_dc_end: assert property (state == ST_TERM_DC && run_any |=> state == ST_IDLE)
        else $error("run did not end terminal DC brake");
    a_estop_refuse: assert property (
        estop_latched && state == ST_IDLE |=> state != ST_RUN && state != ST_START_DC)
        else $error("restart during emergency lockout");
    a_capture_freq: assert property (stop_edge |=> captured_freq == $past(output_freq))
        else $error("stop frequency not captured");
    a_brake_level: assert property (
        state == ST_DCB_STOP |-> ##1 dc_current_pct == $past(brake_pct))
        else $error("brake current level wrong");

    c_ramp_dc: cover property (state == ST_DECEL ##[1:1000] state == ST_STOP_DC);
    c_dcb_stop: cover property (state == ST_BB_WAIT ##[1:1000] state == ST_DCB_STOP);
    c_estop: cover property (state == ST_ESTOP ##[1:1000] state == ST_IDLE);
    c_term_dc: cover property (state == ST_TERM_DC ##1 state == ST_IDLE);
endmodule

// ### stop_seq_pkg.sv
/*
 constants, types and state codes for the motor stop method sequencer.
 assumes one 40 MHz system clock; frequencies in 0.1 Hz, currents in percent.
*/
// What this block does
// - stop method 0: ramp frequency to zero at first decel time.
// - during ramp, below brake start frequency, inject DC for stop time.
// - flux vector control: after stop, behaviour follows low-frequency selection.
// - stop method 1: cut output at once, motor coasts.
// - after coast begins, ignore run until minimum baseblock time passes.
// - stop method 2: block output for baseblock time, then inject DC.
// - DC stop duration uses stop time and captured output frequency.
// - DC stop duration is stop time times ten times frequency over maximum.
// - stop method 3: coast, ignore run until frequency-scaled decel time passes.
// - start injection lasts start time in 0.01 s steps; zero disables it.
// - DC brake current is percent of rated, 0 to 100, default 50.
// - flux vector start excitation uses motor no-load current instead.
// - terminal function 60 held active injects DC while stopped.
// - run or jog during terminal DC brake ends it, operation resumes.
// - analog selector 6 scales brake current; full scale gives 100 percent.
// - terminal code 15 is NO emergency stop, 17 NC; use fast-stop time.
// - after emergency stop, no restart until stopped and run, stop released.
// - below minimum frequency: 0 follow, 1 shut off, 2 clamp, 3 zero.
// - brake start frequency below minimum frequency uses minimum frequency.
package stop_seq_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned STEP_TIME_NS = 10_000_000;
    localparam int unsigned STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam logic [31:0] TENTHS_TO_STEPS = 32'h0000000A;
    localparam logic [31:0] INJ_SCALE = 32'h0000000A;

    // ----------------------------------------
    // selections and codes
    // ----------------------------------------
    localparam logic [1:0] STOP_RAMP = 2'h0;
    localparam logic [1:0] STOP_COAST = 2'h1;
    localparam logic [1:0] STOP_DC_BRAKE = 2'h2;
    localparam logic [1:0] STOP_COAST_TIMER = 2'h3;
    localparam logic [1:0] LOWF_FOLLOW = 2'h0;
    localparam logic [1:0] LOWF_SHUTOFF = 2'h1;
    localparam logic [1:0] LOWF_CLAMP = 2'h2;
    localparam logic [1:0] LOWF_ZERO = 2'h3;
    localparam logic [2:0] CTRL_FLUX_VECTOR = 3'h3;
    localparam logic [0:0] UNIT_HUNDREDTHS = 1'h0;
    localparam logic [7:0] DI_ESTOP_NO = 8'h0F;
    localparam logic [7:0] DI_ESTOP_NC = 8'h11;
    localparam logic [7:0] DI_DC_BRAKE = 8'h3C;
    localparam logic [7:0] AI_DC_CURRENT = 8'h06;
    localparam int NUM_DI = 8;

    // ----------------------------------------
    // scaling and defaults
    // ----------------------------------------
    localparam logic [18:0] AI_FULL_SCALE = 19'h00FFF;
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [6:0] DC_CURRENT_DEFAULT = 7'h32;
    localparam logic [9:0] START_TIME_DEFAULT = 10'h000;
    localparam logic [15:0] FAST_STOP_DEFAULT = 16'h0064;
    localparam logic [15:0] FREQ_RESET = 16'h0000;

    typedef logic [15:0] freq_t;
    typedef logic [31:0] steps_t;

    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_START_DC = 10'h002,
        ST_RUN = 10'h004,
        ST_DECEL = 10'h008,
        ST_STOP_DC = 10'h010,
        ST_COAST = 10'h020,
        ST_BB_WAIT = 10'h040,
        ST_DCB_STOP = 10'h080,
        ST_TERM_DC = 10'h100,
        ST_ESTOP = 10'h200
    } seq_state_t;

endpackage

// ### timer_if.sv
/*
 load/tick/done bundle between the sequencer and its step timers.
 assumes load is a one-cycle pulse and tick a one-cycle 0.01 s step.
*/
`timescale 1ns/1ps
interface timer_if;
    logic load;
    logic [31:0] load_value;
    logic tick;
    logic done;
    modport ctl (output load, output load_value, output tick, input done);
    modport tmr (input load, input load_value, input tick, output done);
endinterface

// ### step_timer.sv
/*
 down counter in 0.01 s steps; done while the count is zero.
 assumes the controller pulses load and tick synchronously to sys_clk.
*/
`timescale 1ns/1ps
module step_timer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control bundle
    timer_if.tmr t
);
    import stop_seq_pkg::*;

    steps_t count;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count <= 32'h00000000;
        end else if (t.load) begin
            count <= t.load_value;
        end else if (t.tick && count != 32'h00000000) begin
            count <= count - 32'h00000001;
        end
    end

    assign t.done = (count == 32'h00000000);
endmodule

// ### terminal_model.sv
/*
 control terminal model: stop contacts and DC brake switch.
 assumes terminal 0 coded 17, terminal 1 coded 60, terminal 2 coded 15.
*/
`timescale 1ns/1ps
module terminal_model (
    // operator requests
    input wire logic estop_req,
    input wire logic estop_no,
    input wire logic dcb_req,
    // terminal levels
    output logic [7:0] di_level
);
    assign di_level[0] = ~(estop_req & ~estop_no);
    assign di_level[1] = dcb_req;
    assign di_level[2] = estop_req & estop_no;
    assign di_level[7:3] = 5'h00;
endmodule

// ### motor_stop_method_sequencer_bench.sv
/*
 self-checking bench: stop methods, terminal brake, analog current, emergency stop.
 assumes design and terminal_model compiled first; four-cycle step tick.
*/
`timescale 1ns/1ps
module motor_stop_method_sequencer_bench;
    import stop_seq_pkg::*;
    logic sys_clk, rst, run_cmd, jog_cmd, estop_req, estop_no, dcb_req;
    logic output_gate_on, dc_inject, output_blocked_state, run_locked, estop_latched;
    logic [7:0] di_level, ai2_fn;
    logic [11:0] ai2_level;
    logic [1:0] stop_method;
    logic [6:0] dc_current_pct;
    freq_t output_freq, captured_freq;
    freq_t freq_ref, brake_freq;
    logic [15:0] decel_time, fstop_time;
    logic [9:0] start_time, stop_time;
    logic [7:0] bb_time;
    logic [6:0] brake_cur, no_load;
    logic [2:0] ctrl_sel;
    logic [1:0] low_sel;
    logic unit_sel, zero_speed_hold;
    int n_mismatch, comparisons, n;
    // method, gate, baseblock, lock just after the stop edge
    logic [4:0] rows [4] = '{5'b00100, 5'b01011, 5'b10011, 5'b11011};
    terminal_model terms (.estop_req(estop_req), .estop_no(estop_no), .dcb_req(dcb_req),
        .di_level(di_level));
    motor_stop_method_sequencer #(.TICK_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst(rst),
        .run_cmd(run_cmd), .jog_cmd(jog_cmd), .di_level(di_level),
        .digital_input_function_select({40'h0, DI_ESTOP_NO, DI_DC_BRAKE, DI_ESTOP_NC}),
        .ai_second_level(ai2_level), .ai_third_level(12'h000),
        .analog_input_second_function(ai2_fn), .analog_input_third_function(8'h00),
        .stop_method_select(stop_method), .low_freq_operation_select(low_sel),
        .control_method_select(ctrl_sel), .freq_reference(freq_ref),
        .dc_brake_start_freq(brake_freq), .dc_brake_current(brake_cur),
        .dc_brake_start_time(start_time), .dc_brake_stop_time(stop_time),
        .min_baseblock_time(bb_time), .decel_time_first(decel_time), .fast_stop_time(fstop_time),
        .accel_decel_time_unit(unit_sel), .motor_no_load_current(no_load),
        .max_output_freq(16'h0028), .min_output_freq(16'h0003), .output_freq(output_freq),
        .output_gate_on(output_gate_on), .dc_inject(dc_inject), .dc_current_pct(dc_current_pct),
        .zero_speed_hold(zero_speed_hold), .output_blocked_state(output_blocked_state),
        .run_locked(run_locked), .estop_latched(estop_latched), .captured_freq(captured_freq));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic busy(input int sel);
        case (sel)
            0: return dc_inject !== 1'b1;
            1: return dc_inject === 1'b1;
            2: return output_freq !== 16'h0000;
            default: return {output_gate_on, run_locked, dc_inject, estop_latched} !== 4'h0;
        endcase
    endfunction
    task automatic wait_on(input int sel);
        n = 0;
        while (busy(sel) && n < 400) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n == 400) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    initial begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        {rst, run_cmd, jog_cmd, estop_req, estop_no, dcb_req} = 6'b100000;
        {ai2_fn, ai2_level, stop_method} = 22'h0;
        {low_sel, ctrl_sel, unit_sel, brake_cur, no_load} = {5'h00, 1'h1, 7'h28, 7'h1E};
        {freq_ref, brake_freq} = {16'h0014, 16'h0005};
        {decel_time, fstop_time} = 32'h00010001;
        {start_time, stop_time, bb_time} = {10'h000, 10'h002, 8'h01};
        repeat (12) @(posedge sys_clk);
        check(output_gate_on, 0);
        rst <= 0;
        repeat (2) @(posedge sys_clk);
        #1;
        check(dc_current_pct, 7'h28);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            stop_method <= rows[i][4:3];
            run_cmd <= 1;
            repeat (3) @(posedge sys_clk);
            run_cmd <= 0;
            @(posedge sys_clk);
            #1;
            check(output_gate_on, rows[i][2]);
            check(output_blocked_state, rows[i][1]);
            check(run_locked, rows[i][0]);
            check(captured_freq, 16'h0014);
            @(posedge sys_clk);
            run_cmd <= 1;
            @(posedge sys_clk);
            run_cmd <= 0;
            #1;
            check(output_gate_on, rows[i][2]);
            if (rows[i][3] == 0) begin
                wait_on(0);
                check(dc_current_pct, 7'h28);
                wait_on(1);
                check(n >= (rows[i][4] ? 37 : 5) && n <= (rows[i][4] ? 44 : 9), 1);
            end
            wait_on(3);
            $display("stop method row %0d done", i);
        end
        @(posedge sys_clk);
        dcb_req <= 1;
        repeat (2) @(posedge sys_clk);
        #1;
        check(dc_inject, 1);
        @(posedge sys_clk);
        jog_cmd <= 1;
        @(posedge sys_clk);
        #1;
        check(dc_inject, 0);
        @(posedge sys_clk);
        {jog_cmd, dcb_req} <= 2'b00;
        wait_on(3);
        @(posedge sys_clk);
        ai2_fn <= AI_DC_CURRENT;
        ai2_level <= 12'hFFF;
        repeat (2) @(posedge sys_clk);
        #1;
        check(dc_current_pct, 7'h64);
        @(posedge sys_clk);
        ai2_fn <= 8'h00;
        $display("terminal brake and analog tests done");
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            {run_cmd, estop_no} <= {1'b1, k[0]};
            repeat (3) @(posedge sys_clk);
            estop_req <= 1;
            repeat (2) @(posedge sys_clk);
            #1;
            check(estop_latched, 1);
            wait_on(2);
            repeat (3) @(posedge sys_clk);
            #1;
            check(output_gate_on, 0);
            @(posedge sys_clk);
            {run_cmd, estop_req} <= 2'b00;
            wait_on(3);
            check(estop_latched, 0);
            $display("emergency stop test %0d done", k);
        end
        @(posedge sys_clk);
        {ctrl_sel, start_time, run_cmd} <= {CTRL_FLUX_VECTOR, 10'h002, 1'h1};
        repeat (2) @(posedge sys_clk);
        #1;
        check(dc_inject, 1);
        check(dc_current_pct, 7'h1E);
        wait_on(1);
        @(posedge sys_clk);
        {freq_ref, low_sel, stop_method} <= {16'h0002, LOWF_CLAMP, STOP_RAMP};
        repeat (2) @(posedge sys_clk);
        #1;
        check(output_freq, 16'h0003);
        @(posedge sys_clk);
        {run_cmd, low_sel} <= {1'h0, LOWF_ZERO};
        repeat (2) @(posedge sys_clk);
        #1;
        check(zero_speed_hold, 1);
        check(dc_inject, 0);
        wait_on(3);
        $display("flux vector start and stop test done");
        print_verdict();
    end
endmodule
